// [dv/mbs_client_model.sv]
// Client model for the register server: sends one query frame, collects the response.
// Assumes the bench fills q and calls send; it drives on falling edges only.
`timescale 1ns/100ps

module mbs_client_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rx_ready_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_last_i,
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_last_o,
  output logic            tx_ready_o
);
  logic [7:0] q [0:511];
  logic [7:0] r [0:511];
  int         rn;
  logic       done;
  logic       slow;

  initial begin
    rx_data_o  = 8'h00;
    rx_valid_o = 1'b0;
    rx_last_o  = 1'b0;
    tx_ready_o = 1'b1;
    slow       = 1'b0;
    rn         = 0;
    done       = 1'b0;
  end

  // Each byte stands until the edge that takes it; bytes go out in frame order.
  task automatic send(input int n);
    rn   = 0;
    done = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys_i);
      rx_data_o  = q[i];
      rx_valid_o = 1'b1;
      rx_last_o  = (i == n - 1);
      do @(posedge clk_sys_i); while (rx_ready_i !== 1'b1);
    end
    @(negedge clk_sys_i);
    rx_valid_o = 1'b0;
    rx_last_o  = 1'b0;
    // A released line shows the inverse so a stale byte can never look valid.
    rx_data_o  = ~rx_data_o;
  endtask : send

  always @(posedge clk_sys_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
      r[rn] = tx_data_i;
      rn    = rn + 1;
      if (tx_last_i === 1'b1) done = 1'b1;
    end
  end

  // Slow mode stalls every other cycle to exercise the response hold.
  always @(negedge clk_sys_i) begin
    tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
  end
endmodule : mbs_client_model

// [dv/mbs_server_tb_top.sv]
// Self-checking bench for the register server with a client model on its byte streams.
// Assumes the server answers each query before taking the next one.
`timescale 1ns/100ps

module mbs_server_tb_top;
  logic       clk_sys_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       conn_close = 1'b0;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_last;
  logic       rx_ready;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_last;
  logic       tx_ready;
  logic [7:0] pl [0:255];
  logic [7:0] e  [0:511];
  int         pn;
  int         mismatches = 0;
  int         tests_run = 0;
  int         cycles = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  mbs_server dut (
    .clk_sys_i    (clk_sys_i),
    .reset_n_i    (reset_n_i),
    .rx_data_i    (rx_data),
    .rx_valid_i   (rx_valid),
    .rx_last_i    (rx_last),
    .rx_ready_o   (rx_ready),
    .tx_data_o    (tx_data),
    .tx_valid_o   (tx_valid),
    .tx_last_o    (tx_last),
    .tx_ready_i   (tx_ready),
    .conn_close_i (conn_close)
  );

  mbs_client_model cl (
    .clk_sys_i  (clk_sys_i),
    .rx_ready_i (rx_ready),
    .tx_data_i  (tx_data),
    .tx_valid_i (tx_valid),
    .tx_last_i  (tx_last),
    .rx_data_o  (rx_data),
    .rx_valid_o (rx_valid),
    .rx_last_o  (rx_last),
    .tx_ready_o (tx_ready)
  );

  task automatic results();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic pe(input logic [31:0] w);
    {e[8], e[9], e[10], e[11]} = w;
  endtask : pe

  // Four data bytes that most normal responses echo back unchanged.
  task automatic p4(input logic [31:0] w);
    {pl[0], pl[1], pl[2], pl[3]} = w;
    pn = 4;
    pe(w);
  endtask : p4

  // Sends pl as a query, then compares the first nc response bytes; ep < 0 means silence.
  task automatic xact(input logic [15:0] tid, input logic [15:0] pid, input logic [7:0] fc,
                      input logic [7:0] efc, input int ep, input int nc);
    logic [15:0] ql;
    logic [15:0] rl;
    ql = 16'(pn + 2);
    rl = 16'(ep + 2);
    {cl.q[0], cl.q[1], cl.q[2], cl.q[3], cl.q[4], cl.q[5]} = {tid, pid, ql};
    cl.q[6] = 8'hFF;
    cl.q[7] = fc;
    for (int i = 0; i < pn; i++) cl.q[8 + i] = pl[i];
    {e[0], e[1], e[2], e[3], e[4], e[5], e[6], e[7]} = {tid, 16'h0000, rl, 8'hFF, efc};
    cl.send(8 + pn);
    for (int i = 0; i < 3000; i++) begin
      if (ep < 0 ? rx_ready === 1'b1 : cl.done === 1'b1) break;
      @(posedge clk_sys_i);
    end
    repeat (4) @(posedge clk_sys_i);
    cmp(16'(cl.rn), ep < 0 ? 16'h0000 : 16'(8 + ep));
    for (int i = 0; i < nc; i++) cmp({8'h00, cl.r[i]}, {8'h00, e[i]});
  endtask : xact

  task automatic s_write_one();
    p4(32'h000D_1770);
    xact(16'hA5C3, 16'h0000, 8'h06, 8'h06, 4, 12);
    p4(32'h000D_0001);
    {e[8], e[9], e[10]} = 24'h02_1770;
    xact(16'h5A3C, 16'h0000, 8'h03, 8'h03, 3, 11);
  endtask : s_write_one

  task automatic s_bad_pid();
    p4(32'h000D_0001);
    xact(16'h1111, 16'h0001, 8'h03, 8'h03, -1, 0);
  endtask : s_bad_pid

  task automatic s_write_multi();
    logic [15:0] wv [0:2] = '{16'h1770, 16'h0BB8, 16'h03E8};
    p4(32'h000C_0003);
    pl[4] = 8'h06;
    for (int i = 0; i < 3; i++) {pl[5 + 2 * i], pl[6 + 2 * i]} = wv[i];
    pn = 11;
    xact(16'h0102, 16'h0000, 8'h10, 8'h10, 4, 12);
    p4(32'h000C_0003);
    e[8] = 8'h06;
    for (int i = 0; i < 3; i++) {e[9 + 2 * i], e[10 + 2 * i]} = wv[i];
    xact(16'hFFFF, 16'h0000, 8'h03, 8'h03, 7, 15);
    pn = 0;
    pe(32'h0003_000C);
    xact(16'h0203, 16'h0000, 8'h46, 8'h46, 4, 12);
  endtask : s_write_multi

  task automatic s_log_clear();
    p4(32'h0000_1234);
    xact(16'h0304, 16'h0000, 8'h08, 8'h08, 4, 12);
    pn = 0;
    pe(32'h0000_0000);
    xact(16'h0405, 16'h0000, 8'h46, 8'h46, 4, 12);
    p4(32'h0020_5A5A);
    xact(16'h0506, 16'h0000, 8'h06, 8'h06, 4, 12);
    @(negedge clk_sys_i);
    conn_close = 1'b1;
    @(negedge clk_sys_i);
    conn_close = 1'b0;
    pn = 0;
    pe(32'h0000_0000);
    xact(16'h0607, 16'h0000, 8'h46, 8'h46, 4, 12);
  endtask : s_log_clear

  task automatic s_errors();
    logic [15:0] qv [0:1] = '{16'h0000, 16'h007E};
    p4(32'h0001_0002);
    e[8] = 8'h01;
    xact(16'h0708, 16'h0000, 8'h2B, 8'hAB, 1, 9);
    for (int i = 0; i < 2; i++) begin
      p4({16'h0000, qv[i]});
      e[8] = 8'h03;
      xact(16'h0809, 16'h0000, 8'h03, 8'h83, 1, 9);
    end
  endtask : s_errors

  // Fill registers 0 to 124 first so the longest read returns known data, never unknowns.
  task automatic s_max_read();
    p4(32'h0000_007B);
    pl[4] = 8'hF6;
    for (int i = 0; i < 123; i++) {pl[5 + 2 * i], pl[6 + 2 * i]} = {8'(i), 8'(i) ^ 8'hA5};
    pn = 251;
    xact(16'h0A0B, 16'h0000, 8'h10, 8'h10, 4, 12);
    p4(32'h007B_0002);
    pl[4] = 8'h04;
    for (int i = 0; i < 2; i++) {pl[5 + 2 * i], pl[6 + 2 * i]} = {8'(123 + i), 8'(123 + i) ^ 8'hA5};
    pn = 9;
    xact(16'h0B0C, 16'h0000, 8'h10, 8'h10, 4, 12);
    cl.slow = 1'b1;
    p4(32'h0000_007D);
    e[8] = 8'hFA;
    for (int i = 0; i < 125; i++) {e[9 + 2 * i], e[10 + 2 * i]} = {8'(i), 8'(i) ^ 8'hA5};
    xact(16'h090A, 16'h0000, 8'h03, 8'h03, 251, 259);
    cl.slow = 1'b0;
  endtask : s_max_read

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    repeat (20) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    s_write_one();
    s_bad_pid();
    s_write_multi();
    s_log_clear();
    s_errors();
    s_max_read();
    results();
  end
endmodule : mbs_server_tb_top

// [hw/mbs_defs.svh]
// Constants for the Modbus TCP register server: frame offsets, codes, limits.
// Assumes the includer is the server or its memory; holds definitions only.
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH

// Byte offsets within a frame.
`define MBS_OFS_TID_HI   9'h000
`define MBS_OFS_PID_HI   9'h002
`define MBS_OFS_PID_LO   9'h003
`define MBS_OFS_LEN_HI   9'h004
`define MBS_OFS_LEN_LO   9'h005
`define MBS_OFS_UID      9'h006
`define MBS_OFS_FC       9'h007
`define MBS_OFS_DATA     9'h008
`define MBS_OFS_BCNT     9'h00C
`define MBS_OFS_WVAL     9'h00D
`define MBS_OFS_RVAL     9'h009
`define MBS_HDR_BYTES    9'h006

// Function codes and the error flag bit.
`define MBS_FC_READ      8'h03
`define MBS_FC_WRITE1    8'h06
`define MBS_FC_DIAG      8'h08
`define MBS_FC_WRITEN    8'h10
`define MBS_FC_LOG       8'h46
`define MBS_FC_ERR_BIT   8'h80
`define MBS_DIAG_ECHO    16'h0000

// Exception codes.
`define MBS_EXC_NONE     8'h00
`define MBS_EXC_FUNC     8'h01
`define MBS_EXC_ADDR     8'h02
`define MBS_EXC_DATA     8'h03

// Limits and expected length field values.
`define MBS_MAX_RD_QTY   16'h007D
`define MBS_MAX_WR_QTY   16'h007B
`define MBS_REG_DEPTH    17'h00100
`define MBS_LEN_FIXED    16'h0006
`define MBS_LEN_LOG      16'h0002
`define MBS_LEN_WRN_BASE 16'h0007
`define MBS_LEN_RD_BASE  16'h0003
`define MBS_LEN_ERR      16'h0003

`endif

// [hw/mbs_pkg.sv]
// Types shared by the Modbus TCP register server.
// Assumes mbs_defs.svh supplies the numeric constants.
package mbs_pkg;

  typedef enum logic [4:0] {
    ST_RECV  = 5'b00001,
    ST_EXEC  = 5'b00010,
    ST_FETCH = 5'b00100,
    ST_LOAD  = 5'b01000,
    ST_SEND  = 5'b10000
  } mbs_state_t;

endpackage : mbs_pkg

// [hw/mbs_regmem.sv]
// Holding register storage, 256 words of 16 bits, one port.
// Assumes one access per cycle; read data appear one cycle after the address.
`timescale 1ns/100ps
`include "mbs_defs.svh"

module mbs_regmem
  import mbs_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o
);

  logic [15:0] mem_r [0:255];

  // The array has no reset; contents are undefined until written.
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= mem_r[addr_i];
    end
  end

endmodule : mbs_regmem

// [hw/mbs_server.sv]
// Modbus TCP register server: takes query bytes, answers with response bytes.
// Assumes a byte stream with a last flag per frame, and that the TCP layer
// signals connection close as a level or pulse.
// Notes on behaviour
// RULE_01: Code 03 returns the requested consecutive registers under the same code.
// RULE_02: Code 06 writes the given 16-bit value into one register.
// RULE_03: Code 08 subfunction 0000 echoes the query unchanged.
// RULE_04: Code 10 writes supplied values into consecutive registers from start.
// RULE_05: Code 46 reports count and start of the last good access.
// RULE_06: After any other function the log reports zero count and address.
// RULE_07: Closing the connection clears the access log; in ST_EXEC of an answered query the new entry wins over a close.
// RULE_08: Transaction identifier is copied unchanged into the response.
// RULE_09: Nonzero protocol identifier gets no response; responses carry zero.
// RULE_10: Length field counts bytes from unit identifier to data end.
// RULE_11: Address field is register number minus 40001.
// RULE_12: Client reads at most 125 registers per query.
// RULE_13: Read byte count is twice the quantity, 2 to 250.
// RULE_14: Read words go high byte first, ascending from start address.
// RULE_15: Errors return code with bit 7 set and an exception code.
// RULE_16: Unsupported function codes get an error response.
// RULE_17: Frame is tid, pid, length, unit id, function, then data.
// RULE_18: Read quantity zero or above maximum gets an error, no data.
// RULE_19: One query at a time; response completes before the next.
`timescale 1ns/100ps
`include "mbs_defs.svh"

module mbs_server
  import mbs_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_valid_i,
  input  wire logic       rx_last_i,
  output logic            rx_ready_o,
  output logic      [7:0] tx_data_o,
  output logic            tx_valid_o,
  output logic            tx_last_o,
  input  wire logic       tx_ready_i,
  input  wire logic       conn_close_i
);

  mbs_state_t  state_r;
  logic [8:0]  rx_idx_r;
  logic [8:0]  tx_idx_r;
  logic [8:0]  tot_r;
  logic [15:0] tid_r, pid_r, len_r, a_r, q_r;
  logic [7:0]  uid_r, fc_r, bc_r, wr_hi_r, lo_r, fc_out_r, exc_r;
  logic [15:0] tlen_r;
  logic [31:0] ext_r;
  logic        is_rd_r;
  logic [7:0]  wcnt_r, rword_r;
  logic [15:0] log_cnt_r, log_addr_r;
  logic        mem_we;
  logic [7:0]  mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic        rx_take, mw_ok, tx_take;
  logic [8:0]  tx_idx_nxt;
  logic [7:0]  exc_nxt;

  // Address plus quantity must stay inside the register array.
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] q);
    in_range = ({1'b0, a} + {1'b0, q}) <= `MBS_REG_DEPTH;
  endfunction : in_range

  // Quantity between one and a limit.
  function automatic logic qty_ok(input logic [15:0] q, input logic [15:0] lim);
    qty_ok = (q != 16'h0000) && (q <= lim);
  endfunction : qty_ok

  // Response byte at an index; read data bytes come from the fetch path instead.
  function automatic logic [7:0] resp_byte(input logic [8:0] i);
    unique case (i)
      9'h000:  resp_byte = tid_r[15:8];
      9'h001:  resp_byte = tid_r[7:0];
      9'h004:  resp_byte = tlen_r[15:8];
      9'h005:  resp_byte = tlen_r[7:0];
      9'h006:  resp_byte = uid_r;
      9'h007:  resp_byte = fc_out_r;
      9'h008:  resp_byte = ext_r[31:24];
      9'h009:  resp_byte = ext_r[23:16];
      9'h00A:  resp_byte = ext_r[15:8];
      9'h00B:  resp_byte = ext_r[7:0];
      default: resp_byte = 8'h00;
    endcase
  endfunction : resp_byte

  mbs_regmem u_mem (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .we_i      (mem_we),
    .addr_i    (mem_addr),
    .wdata_i   (mem_wdata),
    .rdata_o   (mem_rdata)
  );

  assign rx_take    = rx_valid_i && rx_ready_o;
  assign tx_take    = tx_valid_o && tx_ready_i;
  assign tx_idx_nxt = tx_idx_r + 9'h001;
  assign mw_ok      = qty_ok(q_r, `MBS_MAX_WR_QTY) && in_range(a_r, q_r)
                      && (bc_r == {q_r[6:0], 1'b0});

  // Writes stream in during reception; single writes and read fetches use
  // the port later, which cannot collide since one query runs at a time.
  always_comb begin
    mem_we    = 1'b0;
    mem_addr  = a_r[7:0] + rword_r;
    mem_wdata = q_r;
    if (state_r == ST_RECV) begin
      mem_addr  = a_r[7:0] + wcnt_r;
      mem_wdata = {wr_hi_r, rx_data_i};
      mem_we    = rx_take && (fc_r == `MBS_FC_WRITEN) && (rx_idx_r > `MBS_OFS_WVAL)
                  && !rx_idx_r[0] && mw_ok && ({8'h00, wcnt_r} < q_r); // [RULE_04]
    end else if (state_r == ST_EXEC) begin
      mem_addr = a_r[7:0];
      mem_we   = (exc_nxt == `MBS_EXC_NONE) && (pid_r == 16'h0000)
                 && (fc_r == `MBS_FC_WRITE1); // [RULE_02]
    end
  end

  // Field checks, in the order illegal function, data, address.
  always_comb begin
    exc_nxt = `MBS_EXC_NONE;
    unique case (fc_r)
      `MBS_FC_READ: begin
        if (len_r != `MBS_LEN_FIXED || !qty_ok(q_r, `MBS_MAX_RD_QTY)) begin
          exc_nxt = `MBS_EXC_DATA; // [RULE_18]
        end else if (!in_range(a_r, q_r)) begin
          exc_nxt = `MBS_EXC_ADDR;
        end
      end
      `MBS_FC_WRITE1: begin
        if (len_r != `MBS_LEN_FIXED) begin
          exc_nxt = `MBS_EXC_DATA;
        end else if (!in_range(a_r, 16'h0001)) begin
          exc_nxt = `MBS_EXC_ADDR;
        end
      end
      `MBS_FC_DIAG: begin
        if (len_r != `MBS_LEN_FIXED || a_r != `MBS_DIAG_ECHO) begin
          exc_nxt = `MBS_EXC_DATA;
        end
      end
      `MBS_FC_WRITEN: begin
        if (len_r != `MBS_LEN_WRN_BASE + {8'h00, bc_r} || !qty_ok(q_r, `MBS_MAX_WR_QTY)
            || bc_r != {q_r[6:0], 1'b0}) begin
          exc_nxt = `MBS_EXC_DATA;
        end else if (!in_range(a_r, q_r)) begin
          exc_nxt = `MBS_EXC_ADDR;
        end
      end
      `MBS_FC_LOG: begin
        if (len_r != `MBS_LEN_LOG) begin
          exc_nxt = `MBS_EXC_DATA;
        end
      end
      default: exc_nxt = `MBS_EXC_FUNC; // [RULE_16]
    endcase
    if (exc_nxt == `MBS_EXC_NONE && {7'h00, rx_idx_r} != len_r + {7'h00, `MBS_HDR_BYTES}) begin
      exc_nxt = `MBS_EXC_DATA; // [RULE_10]
    end
  end

  // Receive capture of header and data fields.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_idx_r <= 9'h000;
      tid_r    <= 16'h0000;
      pid_r    <= 16'h0000;
      len_r    <= 16'h0000;
      uid_r    <= 8'h00;
      fc_r     <= 8'h00;
      a_r      <= 16'h0000;
      q_r      <= 16'h0000;
      bc_r     <= 8'h00;
      wr_hi_r  <= 8'h00;
      wcnt_r   <= 8'h00;
    end else if (state_r == ST_SEND && tx_take && tx_last_o) begin
      rx_idx_r <= 9'h000;
      wcnt_r   <= 8'h00;
    end else if (state_r == ST_EXEC && pid_r != 16'h0000) begin
      rx_idx_r <= 9'h000;
      wcnt_r   <= 8'h00;
    end else if (rx_take) begin
      if (rx_idx_r != 9'h1FF) begin
        rx_idx_r <= rx_idx_r + 9'h001;
      end
      unique case (rx_idx_r) // [RULE_17]
        9'h000:  tid_r[15:8] <= rx_data_i; // [RULE_08]
        9'h001:  tid_r[7:0]  <= rx_data_i;
        9'h002:  pid_r[15:8] <= rx_data_i;
        9'h003:  pid_r[7:0]  <= rx_data_i;
        9'h004:  len_r[15:8] <= rx_data_i;
        9'h005:  len_r[7:0]  <= rx_data_i;
        9'h006:  uid_r       <= rx_data_i;
        9'h007:  fc_r        <= rx_data_i;
        9'h008:  a_r[15:8]   <= rx_data_i; // [RULE_11]
        9'h009:  a_r[7:0]    <= rx_data_i;
        9'h00A:  q_r[15:8]   <= rx_data_i;
        9'h00B:  q_r[7:0]    <= rx_data_i;
        9'h00C:  bc_r        <= rx_data_i;
        default: begin
          if (rx_idx_r[0]) begin
            wr_hi_r <= rx_data_i; // [RULE_14]
          end else if (mem_we) begin
            wcnt_r <= wcnt_r + 8'h01;
          end
        end
      endcase
    end
  end

  // Sequencer: receive, decide, then send byte by byte.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r    <= ST_RECV;
      rx_ready_o <= 1'b1;
      tx_valid_o <= 1'b0;
      tx_last_o  <= 1'b0;
      tx_data_o  <= 8'h00;
      tx_idx_r   <= 9'h000;
      tot_r      <= 9'h000;
      tlen_r     <= 16'h0000;
      ext_r      <= 32'h0000_0000;
      fc_out_r   <= 8'h00;
      exc_r      <= 8'h00;
      is_rd_r    <= 1'b0;
      lo_r       <= 8'h00;
      rword_r    <= 8'h00;
    end else begin
      unique case (state_r)
        ST_RECV: begin
          if (rx_take && rx_last_i) begin
            state_r    <= ST_EXEC;
            rx_ready_o <= 1'b0; // [RULE_19]
          end
        end
        ST_EXEC: begin
          if (pid_r != 16'h0000) begin
            state_r    <= ST_RECV; // [RULE_09]
            rx_ready_o <= 1'b1;
          end else begin
            state_r    <= ST_SEND;
            exc_r      <= exc_nxt;
            tx_valid_o <= 1'b1;
            tx_last_o  <= 1'b0;
            tx_data_o  <= tid_r[15:8];
            tx_idx_r   <= 9'h000;
            rword_r    <= 8'h00;
            is_rd_r    <= 1'b0;
            if (exc_nxt != `MBS_EXC_NONE) begin
              fc_out_r <= fc_r | `MBS_FC_ERR_BIT; // [RULE_15]
              ext_r    <= {exc_nxt, 24'h000000};
              tlen_r   <= `MBS_LEN_ERR;
              tot_r    <= 9'(`MBS_LEN_ERR) + `MBS_HDR_BYTES;
            end else begin
              fc_out_r <= fc_r;
              ext_r    <= {a_r, q_r}; // [RULE_03]
              tlen_r   <= `MBS_LEN_FIXED;
              tot_r    <= 9'(`MBS_LEN_FIXED) + `MBS_HDR_BYTES; // [RULE_10]
              if (fc_r == `MBS_FC_READ) begin
                is_rd_r <= 1'b1; // [RULE_01]
                ext_r   <= {q_r[6:0], 1'b0, 24'h000000}; // [RULE_13]
                tlen_r  <= `MBS_LEN_RD_BASE + {q_r[14:0], 1'b0};
                tot_r   <= 9'(`MBS_LEN_RD_BASE) + `MBS_HDR_BYTES + {q_r[7:0], 1'b0};
              end else if (fc_r == `MBS_FC_LOG) begin
                ext_r <= {log_cnt_r, log_addr_r}; // [RULE_05]
              end
            end
          end
        end
        ST_SEND: begin
          if (tx_take) begin
            if (tx_last_o) begin
              state_r    <= ST_RECV;
              tx_valid_o <= 1'b0;
              tx_last_o  <= 1'b0;
              rx_ready_o <= 1'b1;
            end else if (is_rd_r && tx_idx_nxt >= `MBS_OFS_RVAL && tx_idx_nxt[0]) begin
              state_r    <= ST_FETCH;
              tx_valid_o <= 1'b0;
              tx_idx_r   <= tx_idx_nxt;
            end else begin
              tx_idx_r  <= tx_idx_nxt;
              tx_last_o <= (tx_idx_nxt == tot_r - 9'h001);
              tx_data_o <= (is_rd_r && tx_idx_nxt > `MBS_OFS_RVAL) ? lo_r
                                                                  : resp_byte(tx_idx_nxt);
            end
          end
        end
        ST_FETCH: begin
          state_r <= ST_LOAD;
        end
        ST_LOAD: begin
          state_r    <= ST_SEND;
          tx_valid_o <= 1'b1;
          tx_data_o  <= mem_rdata[15:8]; // [RULE_14]
          lo_r       <= mem_rdata[7:0];
          rword_r    <= rword_r + 8'h01;
        end
      endcase
    end
  end

  // Access log; a new entry from a finished query wins over a close.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      log_cnt_r  <= 16'h0000;
      log_addr_r <= 16'h0000;
    end else if (state_r == ST_EXEC && pid_r == 16'h0000) begin
      if (exc_nxt == `MBS_EXC_NONE && (fc_r == `MBS_FC_READ || fc_r == `MBS_FC_WRITEN)) begin
        log_cnt_r  <= q_r;
        log_addr_r <= a_r;
      end else if (exc_nxt == `MBS_EXC_NONE && fc_r == `MBS_FC_WRITE1) begin
        log_cnt_r  <= 16'h0001;
        log_addr_r <= a_r;
      end else begin
        log_cnt_r  <= 16'h0000; // [RULE_06]
        log_addr_r <= 16'h0000;
      end
    end else if (conn_close_i) begin
      log_cnt_r  <= 16'h0000; // [RULE_07]
      log_addr_r <= 16'h0000;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  chk_tid_echo: assert property (tx_valid_o && tx_idx_r == 9'h001 |-> tx_data_o == tid_r[7:0]) // [RULE_08]
    else $error("Transaction id low byte not echoed.");
  chk_pid_zero: assert property (tx_valid_o && (tx_idx_r == `MBS_OFS_PID_HI
      || tx_idx_r == `MBS_OFS_PID_LO) |-> tx_data_o == 8'h00) // [RULE_09]
    else $error("Protocol id byte in response is not zero.");
  chk_drop_bad: assert property (state_r == ST_EXEC && pid_r != 16'h0000
      |=> !tx_valid_o [*3]) // [RULE_09]
    else $error("Response sent for nonzero protocol id.");
  chk_len_total: assert property (tx_valid_o && tx_idx_r == `MBS_OFS_LEN_LO
      |-> {7'h00, tot_r} == tlen_r + 16'h0006 && tx_data_o == tlen_r[7:0]) // [RULE_10]
    else $error("Length field disagrees with frame size.");
  chk_err_flag: assert property (tx_valid_o && tx_idx_r == `MBS_OFS_FC && exc_r != 8'h00
      |-> tx_data_o == (fc_r | 8'h80)) // [RULE_15]
    else $error("Error response lacks bit 7 on the function code.");
  chk_byte_count: assert property (tx_valid_o && is_rd_r && tx_idx_r == `MBS_OFS_DATA
      && exc_r == 8'h00 |-> tx_data_o == {q_r[6:0], 1'b0} && tx_data_o >= 8'h02) // [RULE_13]
    else $error("Read byte count is not twice the quantity.");
  chk_busy_hold: assert property (state_r != ST_RECV |-> !rx_ready_o) // [RULE_19]
    else $error("Query accepted while a response is pending.");
  chk_log_clear: assert property (conn_close_i && state_r != ST_EXEC
      |=> log_cnt_r == 16'h0000 && log_addr_r == 16'h0000) // [RULE_07]
    else $error("Access log not cleared on connection close.");
  chk_read_word: assert property (state_r == ST_FETCH |=> state_r == ST_LOAD
      ##1 tx_valid_o && tx_data_o == $past(mem_rdata[15:8])) // [RULE_14]
    else $error("Read data high byte not sent first.");

endmodule : mbs_server
